// [rtl/sdr_data_recovery_unit.sv]
// data recovery unit top: input stage, bit store and word-rate timing
`timescale 1ns/100ps
module sdr_data_recovery_unit
  import sdr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // sampler side
  input wire logic [SAMPLE_W-1:0] sampler_word_out_i,
  input wire logic [3:0] osr_i,
  // timing selection
  input wire logic variant2_i,
  input wire logic [DIV_W-1:0] div_i,
  input wire logic div_half_i,
  // recovered output
  output logic [REC_W-1:0] rec_word_o,
  output logic word_clk_o,
  output logic word_rate_enable_o
);
  logic [SAMPLE_W-1:0] in_a;
  logic [SAMPLE_W-1:0] in_b;
  logic [MAX_BITS-1:0] bits;
  logic [NBIT_W-1:0] nbits;
  logic [ACC_W-1:0] acc;
  logic [LVL_W-1:0] lvl;
  logic [DIV_W-1:0] pcnt;
  logic [DIV_W-1:0] plen;
  logic alt;
  logic started;
  logic [ACC_W-1:0] next_acc;
  logic [LVL_W-1:0] next_lvl;
  logic [DIV_W-1:0] next_pcnt;
  logic [DIV_W-1:0] next_plen;
  logic next_alt;
  logic next_started;
  logic [REC_W-1:0] next_rec;
  logic next_wclk;
  logic next_en;
  logic [DIV_W-1:0] nominal;
  logic period_end;

  // free-running sampler words; nothing here waits on its loop lock
  always_ff @(posedge clk_i) begin
    in_a <= sampler_word_out_i;
    in_b <= in_a;
  end

  sdr_bit_picker #(
    .W(SAMPLE_W)
  ) u_picker (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .word_i(in_b),
    .osr_i(osr_i),
    .bits_o(bits),
    .nbits_o(nbits)
  );

  always_comb begin
    // variant 1 nominal ten; variant 2 the set divider, alternating for halves
    if (variant2_i) begin
      nominal = div_i + {3'b000, div_half_i & alt};
    end else begin
      nominal = V1_DIV;
    end
    period_end = (pcnt == plen - 4'h1);
    next_acc = acc;
    next_lvl = lvl;
    next_pcnt = pcnt + 4'h1;
    next_plen = plen;
    next_alt = alt;
    next_started = started;
    next_rec = rec_word_o;
    next_en = 1'b0;
    if (period_end) begin
      next_pcnt = RST_PERIOD_CNT;
      next_alt = ~alt;
      // the bit store level steers the next period, tracking the real data rate
      if (lvl >= LVL_HIGH) begin
        next_plen = nominal - 4'h1;
      end else if (lvl < LVL_LOW + 5'h00002) begin
        next_plen = nominal + 4'h1;
      end else begin
        next_plen = nominal;
      end
      if (lvl >= LVL_LOW) begin
        next_rec = acc[REC_W-1:0];
        next_acc = acc >> REC_W;
        next_lvl = lvl - LVL_LOW;
        next_en = 1'b1;
        next_started = 1'b1;
      end
    end
    for (int i = 0; i < MAX_BITS; i++) begin
      if (i < int'(nbits) && int'(next_lvl) < ACC_W) begin
        next_acc[next_lvl] = bits[i];
        next_lvl = next_lvl + 5'h00001;
      end
    end
    // word clock high during the first half rounded up, so a three-cycle period still holds it
    // for two cycles; it only ever rises with an enable, so a refused period keeps it low
    next_wclk = started && word_clk_o && (next_pcnt != RST_PERIOD_CNT) &&
      (next_pcnt < (next_plen - {1'b0, next_plen[DIV_W-1:1]}));
    if (next_en) begin
      next_wclk = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      acc <= '0;
      lvl <= '0;
      pcnt <= RST_PERIOD_CNT;
      plen <= V1_DIV;
      alt <= 1'b0;
      started <= 1'b0;
      rec_word_o <= '0;
      word_clk_o <= 1'b0;
      word_rate_enable_o <= 1'b0;
    end else begin
      acc <= next_acc;
      lvl <= next_lvl;
      pcnt <= next_pcnt;
      plen <= next_plen;
      alt <= next_alt;
      started <= next_started;
      rec_word_o <= next_rec;
      word_clk_o <= next_wclk;
      word_rate_enable_o <= next_en;
    end
  end
endmodule // sdr_data_recovery_unit

// [rtl/sdr_pkg.sv]
// constants for the over-sampled data recovery unit
// Operation
// - detect transitions, pick sample point, output bits
// - works for eight to eleven times over-sampling
// - no reliance on sampler clock recovery lock
// - variant 1 divides reference clock by ten
// - variant 1 stretches period to nine or eleven
// - variant 1 data changes on word clock rise
// - variant 1 tolerates unlocked local reference
// - variant 2 one-cycle enable per division period
// - variant 2 divides by four to ten, halves
// - variant 2 inserts or removes one cycle
// - variant 2 data updates only with enable
// - sampler clock moves words into input stage
package sdr_pkg;
  localparam int SAMPLE_W = 20;
  localparam int REC_W = 10;
  localparam int CNT_W = 5;
  localparam int NBIT_W = 2;
  localparam int MAX_BITS = 3;
  localparam int ACC_W = 24;
  localparam int LVL_W = 5;
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] V1_DIV = 4'h000a;
  localparam logic [LVL_W-1:0] LVL_LOW = 5'h0000a;
  localparam logic [LVL_W-1:0] LVL_HIGH = 5'h00010;
  localparam logic [DIV_W-1:0] RST_PERIOD_CNT = 4'h0000;
  localparam logic [CNT_W-1:0] RST_RUN_CNT = 5'h00000;
endpackage

// [rtl/sdr_bit_picker.sv]
// bit picker: finds transitions in one sample word and emits centred bits
`timescale 1ns/100ps
module sdr_bit_picker
  import sdr_pkg::*;
#(
  parameter int W = SAMPLE_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // sample word in
  input wire logic [W-1:0] word_i,
  input wire logic [3:0] osr_i,
  // bits out
  output logic [MAX_BITS-1:0] bits_o,
  output logic [NBIT_W-1:0] nbits_o
);
  logic prev;
  logic [CNT_W-1:0] run;
  logic next_prev;
  logic [CNT_W-1:0] next_run;
  logic [MAX_BITS-1:0] next_bits;
  logic [NBIT_W-1:0] next_nbits;
  logic [CNT_W-1:0] half;
  logic [CNT_W-1:0] wrap;

  // a transition restarts the run count, so any rate from 8x to 11x resyncs each edge
  always_comb begin
    half = {2'b00, osr_i[3:1]};
    wrap = half + {1'b0, osr_i};
    next_prev = prev;
    next_run = run;
    next_bits = '0;
    next_nbits = '0;
    for (int i = 0; i < W; i++) begin
      if (word_i[i] != next_prev) begin
        next_run = '0;
      end else if (next_run != {CNT_W{1'b1}}) begin
        next_run = next_run + 5'h0001;
      end
      if (next_run == wrap) begin
        next_run = half;
      end
      // extra decisions beyond three per word are dropped; cannot occur at 8x or slower
      if (next_run == half && next_nbits != 2'h3) begin
        next_bits[next_nbits] = word_i[i];
        next_nbits = next_nbits + 2'h1;
      end
      next_prev = word_i[i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prev <= 1'b0;
      run <= RST_RUN_CNT;
      bits_o <= '0;
      nbits_o <= '0;
    end else begin
      prev <= next_prev;
      run <= next_run;
      bits_o <= next_bits;
      nbits_o <= next_nbits;
    end
  end
endmodule // sdr_bit_picker

// [sim/sdr_sampler_model.sv]
// over-sampler model of an alternating bitstream
`timescale 1ns/100ps
module sdr_sampler_model (
  input wire logic clk_i,
  input wire logic [3:0] osr_i,
  input wire logic flat_i,
  output logic [19:0] word_o = '0
);
  int unsigned s = 0;
  // free-running: no lock to the bitstream, just osr samples per bit
  always @(posedge clk_i) begin
    // flat_i gives a steady high line, immune to bits lost when the bit store is full
    for (int i = 0; i < 20; i++) word_o[i] <= flat_i || ((((s + i) / osr_i) % 2) != 0);
    s <= s + 20;
  end
endmodule // sdr_sampler_model

// [sim/sdr_data_recovery_unit_props.sv]
// assertions on the data recovery unit ports
`timescale 1ns/100ps
module sdr_data_recovery_unit_props
  import sdr_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic variant2_i,
  input wire logic [DIV_W-1:0] div_i,
  input wire logic div_half_i,
  input wire logic [REC_W-1:0] rec_word_o,
  input wire logic word_clk_o,
  input wire logic word_rate_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire en = word_rate_enable_o;
  wire [4:0] nom = variant2_i ? 5'(div_i) : 5'h0a;
  logic [4:0] gap;
  logic [4:0] next_gap;
  // saturating distance since last enable, 0 until the first one
  always_comb next_gap = en ? 5'h01 : (gap != 0 && gap != 31) ? gap + 5'h01 : gap;
  always_ff @(posedge clk_i) gap <= sys_rst_i ? 5'h00 : next_gap;
  a_en_single: assert property (en |=> !en) else $error("enable longer than one cycle");
  a_data_hold: assert property (!en |-> $stable(rec_word_o)) else $error("data moved");
  a_clk_rise: assert property ($rose(word_clk_o) |-> en) else $error("clock rise alone");
  a_clk_high: assert property (en |-> word_clk_o ##1 word_clk_o) else $error("clock low");
  a_v1_min: assert property (!variant2_i && en |=> !en [*8]) else $error("short period");
  a_v2_min: assert property (variant2_i && en |=> !en [*2]) else $error("short gap");
  a_gap_range: assert property (en && gap != 0 |-> gap >= nom - 1 &&
    gap <= nom + 1 + 5'(div_half_i)) else $error("period out of range");
  a_rst_quiet: assert property ($fell(sys_rst_i) |->
    (!en && rec_word_o == '0 && !word_clk_o) [*4]) else $error("busy after reset");
endmodule // sdr_data_recovery_unit_props

// [sim/sdr_data_recovery_unit_tb.sv]
// testbench for the data recovery unit
`timescale 1ns/100ps
module sdr_data_recovery_unit_tb;
  import sdr_pkg::*;
  logic clk_i = 0, sys_rst_i = 1, variant2_i = 0, div_half_i = 0, flat = 0;
  logic [3:0] osr_i = 4'h8;
  logic [DIV_W-1:0] div_i = 4'h4;
  logic [SAMPLE_W-1:0] smp;
  logic [REC_W-1:0] rec_word_o;
  logic word_clk_o, word_rate_enable_o;
  int fail_count = 0, total_checks = 0, cyc = 0;
  sdr_sampler_model i_sdr_sampler_model (.clk_i(clk_i), .osr_i(osr_i), .flat_i(flat),
    .word_o(smp));
  sdr_data_recovery_unit i_sdr_data_recovery_unit (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .sampler_word_out_i(smp), .osr_i(osr_i), .variant2_i(variant2_i), .div_i(div_i),
    .div_half_i(div_half_i), .rec_word_o(rec_word_o), .word_clk_o(word_clk_o),
    .word_rate_enable_o(word_rate_enable_o));
  initial forever #5 clk_i = ~clk_i;
  // four runs of about 260 cycles each
  always @(posedge clk_i) if (++cyc == 3000) begin
    fail_count++;
    finish_test();
  end
  task automatic chk(string name, int lo, int hi, int got);
    total_checks++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask
  // counts enables over 200 cycles; alternating bits give only two legal words
  // variant 1 on one clock gets more bits than it can hand on, so it runs on a flat line
  task automatic run(logic v2, logic [3:0] d, logic h, logic [3:0] o, logic f, int lo, int hi);
    int n;
    n = 0;
    sys_rst_i <= 1;
    variant2_i <= v2;
    div_i <= d;
    div_half_i <= h;
    osr_i <= o;
    flat <= f;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 0;
    repeat (50) @(posedge clk_i);
    repeat (200) begin
      @(posedge clk_i);
      #1;
      if (word_rate_enable_o === 1'b1) begin
        n++;
        chk("word", 1, 1, int'(f ? rec_word_o === 10'h03ff :
          (rec_word_o === 10'h0155 || rec_word_o === 10'h02aa)));
      end
    end
    chk("enables", lo, hi, n);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    run(1'b1, 4'h5, 1'b0, 4'hb, 1'b0, 35, 38);
    run(1'b1, 4'h4, 1'b1, 4'ha, 1'b0, 39, 41);
    run(1'b1, 4'h4, 1'b0, 4'h8, 1'b0, 49, 51);
    run(1'b0, 4'h4, 1'b0, 4'hb, 1'b1, 21, 23);
    finish_test();
  end
endmodule // sdr_data_recovery_unit_tb
bind sdr_data_recovery_unit sdr_data_recovery_unit_props i_props (.clk_i, .sys_rst_i,
  .variant2_i, .div_i, .div_half_i, .rec_word_o, .word_clk_o, .word_rate_enable_o);
